/* bench/ssf_host_model.sv */
`timescale 1ns/1ns
`include "ssf_params.svh"

module ssf_host_model (
    input wire logic clk, // Clock
    input wire logic [`SSF_BYTE_W-1:0] reg_rdata, // Read data
    output logic [`SSF_ADDR_W-1:0] reg_addr, // Register address
    output logic [`SSF_BYTE_W-1:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd // Read strobe
);
    // ----------------------------------------
    // Register cycles; idle bus shows inverted last value
    // ----------------------------------------
    initial begin
        reg_addr = 8'hff;
        reg_wdata = 8'hff;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // ssf_host_model

/* bench/ssf_sample_fifo_assertions.sv */
`timescale 1ns/1ns
`include "ssf_params.svh"

module ssf_sample_fifo_checker (
    input wire logic clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic [`SSF_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [`SSF_BYTE_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [`SSF_BYTE_W-1:0] reg_rdata, // Read data
    input wire logic sample_valid, // New sample
    input wire logic [`SSF_ELEMS*`SSF_ELEM_W-1:0] sample_data, // Sample elements
    input wire logic store_full, // Store full
    input wire logic flush_done // Flush pulse
);
    // ----------------------------------------
    // Enable shadow and flush causes
    // ----------------------------------------
    logic en;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en <= 1'b0;
        end else if (reg_wr && reg_addr == `SSF_REG_SYS_CTRL) begin
            en <= reg_wdata[0];
        end
    end
    wire cfg_wr = reg_wr && (reg_addr == `SSF_REG_STORE_CFG || reg_addr == `SSF_REG_SAMPLE_CFG);
    wire en_rise = reg_wr && reg_addr == `SSF_REG_SYS_CTRL && reg_wdata[0] && !en;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_flush_on_cfg: assert property (cfg_wr && en |=> flush_done) else $error("no flush on config write");
    a_flush_on_rise: assert property (en_rise |=> flush_done) else $error("no flush on enable rise");
    a_no_flush_off: assert property (cfg_wr && !en |=> !flush_done) else $error("flush while disabled");
    a_flush_has_cause: assert property (flush_done |-> $past(reg_wr)) else $error("flush without write");
    a_flush_empties: assert property (flush_done |-> !store_full) else $error("full after flush");
    a_flush_wr_zero: assert property ($past(cfg_wr && en, 2) && !$past(sample_valid) && reg_rd
        && reg_addr == `SSF_REG_WR_IDX |=> reg_rdata == 8'h00) else $error("write index kept");
    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without strobe");
    a_lost_range: assert property (reg_rd && reg_addr == `SSF_REG_LOST |=> reg_rdata[7:5] == 3'h0)
        else $error("lost count too wide");
    a_full_held: assert property (!en && !reg_wr |=> $stable(store_full)) else $error("full moved");
    a_full_by_push: assert property ($rose(store_full) |-> $past(sample_valid && en))
        else $error("full without push");
    c_rise: cover property (en_rise ##1 flush_done);
    c_full: cover property ($rose(store_full));
    c_data: cover property (reg_rd && reg_addr == `SSF_REG_DATA);
endmodule // ssf_sample_fifo_checker

bind ssf_sample_fifo ssf_sample_fifo_checker ssf_sample_fifo_checker_inst (.clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .sample_data, .store_full, .flush_done);

/* bench/tb_ssf_sample_fifo.sv */
`timescale 1ns/1ns
`include "ssf_params.svh"

module tb_ssf_sample_fifo;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sample_valid = 1'b0;
    logic [`SSF_ELEMS*`SSF_ELEM_W-1:0] sample_data = '0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, store_full, flush_done;
    int failures = 0;
    int compares = 0;
    always #2 clk = ~clk;
    ssf_host_model ssf_host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    ssf_sample_fifo ssf_sample_fifo_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .sample_data(sample_data), .store_full(store_full), .flush_done(flush_done));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [95:0] sdat(input int i);
        sdat = '0;
        for (int k = 0; k < 4; k++) sdat[k*24 +: 24] = {8'(i), 8'(k + 1), 8'(8'ha5 ^ i)};
    endfunction
    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        ssf_host_model_inst.wr(a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        ssf_host_model_inst.rd(a, v);
        chk(what, v, e);
    endtask
    task automatic push(input int i);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_data <= sdat(i);
        @(posedge clk);
        sample_valid <= 1'b0;
        sample_data <= ~sdat(i);
    endtask
    task automatic rsamp(input int i, input int j0, input int j1);
        logic [95:0] s;
        s = sdat(i);
        for (int j = j0; j < j1; j++) rchk("data", `SSF_REG_DATA, s[(j/3)*24 + (2-j%3)*8 +: 8]);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        w(`SSF_REG_SYS_CTRL, 8'h01);
        for (int i = 0; i < 3; i++) push(i);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h03);
        rchk("unmapped", 8'h01, 8'h00);
        rsamp(0, 0, 11);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h00);
        rsamp(0, 11, 12);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h01);
        w(`SSF_REG_SYS_CTRL, 8'h00);
        w(`SSF_REG_STORE_CFG, 8'h00);
        push(9);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h03);
        rsamp(1, 0, 12);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h01);
        w(`SSF_REG_SYS_CTRL, 8'h01);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h00);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h00);
        rchk("wiped", `SSF_REG_DATA, 8'h00);
        w(`SSF_REG_RD_IDX, 8'h00);
        for (int i = 0; i < 32; i++) push(i);
        @(negedge clk);
        chk("full", {7'h00, store_full}, 8'h01);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h00);
        for (int i = 0; i < 40; i++) push(100 + i);
        rchk("lost", `SSF_REG_LOST, 8'h1f);
        rsamp(0, 0, 12);
        rchk("lost", `SSF_REG_LOST, 8'h00);
        for (int i = 1; i < 32; i++) rsamp(i, 0, 12);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h00);
        push(7);
        w(`SSF_REG_SYS_CTRL, 8'h03);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h00);
        push(7);
        w(`SSF_REG_SAMPLE_CFG, 8'h11);
        rchk("wr_idx", `SSF_REG_WR_IDX, 8'h00);
        w(`SSF_REG_STORE_CFG, 8'h03);
        for (int i = 0; i < 33; i++) push(i);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h01);
        for (int i = 1; i < 33; i++) rsamp(i, 0, 6);
        rchk("rd_idx", `SSF_REG_RD_IDX, 8'h01);
        rchk("lost", `SSF_REG_LOST, 8'h00);
        results();
    end
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule // tb_ssf_sample_fifo

/* hw/ssf_byte_reader.sv */
`timescale 1ns/1ns
`include "ssf_params.svh"

module ssf_byte_reader import ssf_pkg::*; (
    input wire logic clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic restart, // Back to first byte of a sample
    input wire logic step, // One data byte taken by the host
    input wire logic two_elem, // Only two elements active
    input ssf_elem_t elem_in, // Element at the current slot
    output logic [`SSF_SLOT_W-1:0] slot, // Current element slot
    output logic [`SSF_BYTE_W-1:0] byte_out, // Byte at the current position
    output logic sample_done // Last byte of a sample taken
);

    ssf_byte_t pos;
    ssf_byte_t next_pos;
    logic [`SSF_SLOT_W-1:0] next_slot;

    wire logic [`SSF_SLOT_W-1:0] last_slot = two_elem ? `SSF_SLOT_LAST_TWO : `SSF_SLOT_LAST_FOUR;
    wire logic elem_done = step && (pos == SSF_BYTE_LO);

    // ------------------------------------------------------------
    // Byte order: high, middle, low
    // ------------------------------------------------------------
    assign byte_out = (pos == SSF_BYTE_HI) ? elem_in[2*`SSF_BYTE_W +: `SSF_BYTE_W] :
                      (pos == SSF_BYTE_MID) ? elem_in[`SSF_BYTE_W +: `SSF_BYTE_W] :
                      elem_in[`SSF_BYTE_W-1:0];
    assign sample_done = elem_done && (slot == last_slot);

    always_comb begin
        next_pos = pos;
        unique case (pos)
            SSF_BYTE_HI: next_pos = SSF_BYTE_MID;
            SSF_BYTE_MID: next_pos = SSF_BYTE_LO;
            SSF_BYTE_LO: next_pos = SSF_BYTE_HI;
            default: next_pos = SSF_BYTE_HI;
        endcase
    end

    assign next_slot = sample_done ? `SSF_SLOT_ZERO : slot + `SSF_SLOT_ONE;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos <= SSF_BYTE_HI;
            slot <= `SSF_SLOT_ZERO;
        end else if (restart) begin
            pos <= SSF_BYTE_HI;
            slot <= `SSF_SLOT_ZERO;
        end else if (step) begin
            pos <= next_pos;
            if (elem_done) begin
                slot <= next_slot;
            end
        end
    end

endmodule // ssf_byte_reader

/* hw/ssf_params.svh */
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define SSF_IDX_W 5
`define SSF_SLOT_W 2
`define SSF_ELEM_W 24
`define SSF_ELEMS 4
`define SSF_BYTE_W 8

// ------------------------------------------------------------
// Register port
// ------------------------------------------------------------
`define SSF_ADDR_W 8
`define SSF_REG_WR_IDX 8'h04
`define SSF_REG_LOST 8'h05
`define SSF_REG_RD_IDX 8'h06
`define SSF_REG_DATA 8'h07
`define SSF_REG_STORE_CFG 8'h08
`define SSF_REG_SAMPLE_CFG 8'h0a
`define SSF_REG_SYS_CTRL 8'h0d

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SSF_CFG_OVERWRITE_BIT 0
`define SSF_CFG_TWO_ELEM_BIT 1
`define SSF_CTRL_ENABLE_BIT 0
`define SSF_CTRL_PROXIMITY_MODE_BIT 1

// ------------------------------------------------------------
// Values
// ------------------------------------------------------------
`define SSF_IDX_ZERO 5'h00
`define SSF_IDX_ONE 5'h01
`define SSF_LOST_ZERO 5'h00
`define SSF_LOST_MAX 5'h1f
`define SSF_BYTE_ZERO 8'h00
`define SSF_SLOT_ZERO 2'h0
`define SSF_SLOT_ONE 2'h1
`define SSF_SLOT_LAST_TWO 2'h1
`define SSF_SLOT_LAST_FOUR 2'h3
`define SSF_ELEM_ZERO 24'h000000

`endif

/* hw/ssf_pkg.sv */
`include "ssf_params.svh"

package ssf_pkg;

    typedef logic [`SSF_ELEM_W-1:0] ssf_elem_t;

    typedef enum logic [1:0] {
        SSF_BYTE_HI,
        SSF_BYTE_MID,
        SSF_BYTE_LO
    } ssf_byte_t;

endpackage

/* hw/ssf_sample_fifo.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "ssf_params.svh"

// Overview of operation
// - Flush zeroes both indices, wipes store
// - Enable set: each new sample pushed
// - Enable clear: indices and data held
// - Word address is index times four plus slot
// - Thirty-two samples, last word 0x7f
// - Two elements use first two slots
// - Flush on enable rise; while enabled, on config writes, proximity
// - Full: overwrite drops oldest, else newest
// - Lost count saturates, clears when a whole sample is popped
// - Read index advances after whole sample
module ssf_sample_fifo import ssf_pkg::*; #(
    parameter int IDX_W = `SSF_IDX_W,
    parameter int SLOT_W = `SSF_SLOT_W
) (
    input wire logic clk, // Clock, 250 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic [`SSF_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [`SSF_BYTE_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [`SSF_BYTE_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic sample_valid, // New sample produced, one cycle
    input wire logic [`SSF_ELEMS*`SSF_ELEM_W-1:0] sample_data, // Elements, element 1 lowest
    output logic store_full, // Store holds 32 samples
    output logic flush_done // Pulse: store was flushed
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [IDX_W-1:0] store_write_index;
    logic [IDX_W-1:0] store_read_index;
    logic [`SSF_IDX_W-1:0] lost_sample_count;
    logic overwrite_when_full;
    logic two_elem;
    logic store_enable;
    logic proximity_mode;
    logic [`SSF_BYTE_W-1:0] sample_cfg;
    logic full;

    logic [IDX_W-1:0] next_write_index;
    logic [IDX_W-1:0] next_read_index;
    logic [`SSF_IDX_W-1:0] next_lost;
    logic next_full;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic reg_is(input logic [`SSF_ADDR_W-1:0] a, input logic [`SSF_ADDR_W-1:0] r);
        reg_is = (a == r);
    endfunction

    wire logic wr_rd_idx = reg_wr && reg_is(reg_addr, `SSF_REG_RD_IDX);
    wire logic wr_store_cfg = reg_wr && reg_is(reg_addr, `SSF_REG_STORE_CFG);
    wire logic wr_sample_cfg = reg_wr && reg_is(reg_addr, `SSF_REG_SAMPLE_CFG);
    wire logic wr_sys_ctrl = reg_wr && reg_is(reg_addr, `SSF_REG_SYS_CTRL);
    wire logic rd_data_reg = reg_rd && reg_is(reg_addr, `SSF_REG_DATA);

    wire logic new_enable = reg_wdata[`SSF_CTRL_ENABLE_BIT];
    wire logic new_proximity_mode = reg_wdata[`SSF_CTRL_PROXIMITY_MODE_BIT];

    // ------------------------------------------------------------
    // Flush sources
    // ------------------------------------------------------------
    wire logic flush_cfg = store_enable && (wr_store_cfg || wr_sample_cfg);
    wire logic flush_rise = wr_sys_ctrl && new_enable && !store_enable;
    wire logic flush_proximity_mode = wr_sys_ctrl && new_enable && store_enable
                            && (new_proximity_mode != proximity_mode);
    wire logic flush = flush_cfg || flush_rise || flush_proximity_mode;

    // ------------------------------------------------------------
    // Byte reader and storage
    // ------------------------------------------------------------
    logic [SLOT_W-1:0] rd_slot;
    logic [`SSF_BYTE_W-1:0] rd_byte;
    logic sample_done;
    ssf_elem_t rd_elem;
    wire logic reader_restart = flush || wr_rd_idx;

    ssf_byte_reader u_reader (
        .clk(clk),
        .nrst(nrst),
        .restart(reader_restart),
        .step(rd_data_reg),
        .two_elem(two_elem),
        .elem_in(rd_elem),
        .slot(rd_slot),
        .byte_out(rd_byte),
        .sample_done(sample_done)
    );

    // Popping is frozen while the store is disabled
    wire logic pop = sample_done && store_enable && !flush;

    // ------------------------------------------------------------
    // Push decisions
    // ------------------------------------------------------------
    wire logic push_req = sample_valid && store_enable && !flush;
    wire logic full_now = full && !pop;
    wire logic push_store = push_req && (!full_now || overwrite_when_full);
    wire logic drop_oldest = push_req && full_now && overwrite_when_full;
    wire logic lost_event = push_req && full_now;

    ssf_sample_ram #(
        .IDX_W(IDX_W),
        .SLOT_W(SLOT_W)
    ) u_ram (
        .clk(clk),
        .nrst(nrst),
        .clear(flush),
        .wr_en(push_store),
        .wr_two(two_elem),
        .wr_index(store_write_index),
        .wr_data(sample_data),
        .rd_addr({store_read_index, rd_slot}),
        .rd_data(rd_elem)
    );

    // ------------------------------------------------------------
    // Next index values
    // ------------------------------------------------------------
    // Flush outranks a push or pop in the same cycle
    always_comb begin
        next_write_index = store_write_index;
        next_read_index = store_read_index;
        if (flush) begin
            next_write_index = IDX_W'(`SSF_IDX_ZERO);
            next_read_index = IDX_W'(`SSF_IDX_ZERO);
        end else begin
            if (push_store) begin
                next_write_index = store_write_index + IDX_W'(`SSF_IDX_ONE);
            end
            if (wr_rd_idx) begin
                next_read_index = reg_wdata[IDX_W-1:0];
            end else if (pop || drop_oldest) begin
                next_read_index = store_read_index + IDX_W'(`SSF_IDX_ONE);
            end
        end
    end

    always_comb begin
        next_full = full;
        if (flush || wr_rd_idx) begin
            next_full = 1'b0;
        end else if (push_store && !drop_oldest) begin
            next_full = (next_write_index == next_read_index);
        end else if (pop) begin
            next_full = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Lost sample count
    // ------------------------------------------------------------
    always_comb begin
        next_lost = lost_sample_count;
        if (flush) begin
            next_lost = `SSF_LOST_ZERO;
        end else if (lost_event) begin
            if (lost_sample_count != `SSF_LOST_MAX) begin
                next_lost = lost_sample_count + `SSF_IDX_ONE;
            end
        end else if (pop) begin
            next_lost = `SSF_LOST_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire logic [`SSF_BYTE_W-1:0] cfg_byte = {{(`SSF_BYTE_W-2){1'b0}}, two_elem, overwrite_when_full};
    wire logic [`SSF_BYTE_W-1:0] ctrl_byte = {{(`SSF_BYTE_W-2){1'b0}}, proximity_mode, store_enable};
    wire logic [`SSF_BYTE_W-1:0] wr_idx_byte = `SSF_BYTE_W'(store_write_index);
    wire logic [`SSF_BYTE_W-1:0] rd_idx_byte = `SSF_BYTE_W'(store_read_index);
    wire logic [`SSF_BYTE_W-1:0] lost_byte = `SSF_BYTE_W'(lost_sample_count);

    wire logic sel_wr_idx = reg_is(reg_addr, `SSF_REG_WR_IDX);
    wire logic sel_lost = reg_is(reg_addr, `SSF_REG_LOST);
    wire logic sel_rd_idx = reg_is(reg_addr, `SSF_REG_RD_IDX);
    wire logic sel_data = reg_is(reg_addr, `SSF_REG_DATA);
    wire logic sel_store_cfg = reg_is(reg_addr, `SSF_REG_STORE_CFG);
    wire logic sel_sample_cfg = reg_is(reg_addr, `SSF_REG_SAMPLE_CFG);
    wire logic sel_sys_ctrl = reg_is(reg_addr, `SSF_REG_SYS_CTRL);

    wire logic [`SSF_BYTE_W-1:0] read_mux =
        sel_wr_idx ? wr_idx_byte :
        sel_lost ? lost_byte :
        sel_rd_idx ? rd_idx_byte :
        sel_data ? rd_byte :
        sel_store_cfg ? cfg_byte :
        sel_sample_cfg ? sample_cfg :
        sel_sys_ctrl ? ctrl_byte : `SSF_BYTE_ZERO;

    // ------------------------------------------------------------
    // Index and flag registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            store_write_index <= IDX_W'(`SSF_IDX_ZERO);
        end else begin
            store_write_index <= next_write_index;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            store_read_index <= IDX_W'(`SSF_IDX_ZERO);
        end else begin
            store_read_index <= next_read_index;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lost_sample_count <= `SSF_LOST_ZERO;
        end else begin
            lost_sample_count <= next_lost;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            full <= 1'b0;
        end else begin
            full <= next_full;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overwrite_when_full <= 1'b0;
        end else if (wr_store_cfg) begin
            overwrite_when_full <= reg_wdata[`SSF_CFG_OVERWRITE_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            two_elem <= 1'b0;
        end else if (wr_store_cfg) begin
            two_elem <= reg_wdata[`SSF_CFG_TWO_ELEM_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sample_cfg <= `SSF_BYTE_ZERO;
        end else if (wr_sample_cfg) begin
            sample_cfg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            store_enable <= 1'b0;
        end else if (wr_sys_ctrl) begin
            store_enable <= new_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            proximity_mode <= 1'b0;
        end else if (wr_sys_ctrl) begin
            proximity_mode <= new_proximity_mode;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `SSF_BYTE_ZERO;
        end else begin
            reg_rdata <= reg_rd ? read_mux : `SSF_BYTE_ZERO;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            store_full <= 1'b0;
        end else begin
            store_full <= next_full;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flush_done <= 1'b0;
        end else begin
            flush_done <= flush;
        end
    end

endmodule // ssf_sample_fifo

/* hw/ssf_sample_ram.sv */
`timescale 1ns/1ns
`include "ssf_params.svh"

module ssf_sample_ram import ssf_pkg::*; #(
    parameter int IDX_W = `SSF_IDX_W,
    parameter int SLOT_W = `SSF_SLOT_W
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic clear, // Wipe all words
    input wire logic wr_en, // Store one sample group
    input wire logic wr_two, // Only two elements active
    input wire logic [IDX_W-1:0] wr_index, // Sample index to store at
    input wire logic [`SSF_ELEMS*`SSF_ELEM_W-1:0] wr_data, // Elements, element 1 lowest
    input wire logic [IDX_W+SLOT_W-1:0] rd_addr, // Physical word address
    output ssf_elem_t rd_data // Word at rd_addr
);

    // ------------------------------------------------------------
    // Slot use
    // ------------------------------------------------------------
    function automatic logic slot_used(input logic two, input logic [SLOT_W-1:0] slot);
        slot_used = !two || (slot <= SLOT_W'(`SSF_SLOT_LAST_TWO));
    endfunction

    ssf_elem_t mem [1 << (IDX_W + SLOT_W)];

    // ------------------------------------------------------------
    // Storage words
    // ------------------------------------------------------------
    for (genvar w = 0; w < (1 << (IDX_W + SLOT_W)); w++) begin : g_word
        localparam logic [IDX_W-1:0] GRP = IDX_W'(w >> SLOT_W);
        localparam logic [SLOT_W-1:0] SLT = SLOT_W'(w % (1 << SLOT_W));
        wire logic hit = wr_en && (wr_index == GRP) && slot_used(wr_two, SLT);
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                mem[w] <= `SSF_ELEM_ZERO;
            end else if (clear) begin
                mem[w] <= `SSF_ELEM_ZERO;
            end else if (hit) begin
                mem[w] <= wr_data[SLT*`SSF_ELEM_W +: `SSF_ELEM_W];
            end
        end
    end

    assign rd_data = mem[rd_addr];

endmodule // ssf_sample_ram
